// File: core/cdr_pkg.sv
package cdr_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          AV_ADDR_W   = 4;
  localparam int          AV_DATA_W   = 32;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_DATA    = 4'h4;
  localparam logic [3:0]  REG_STATUS  = 4'h8;

  // ************************************************************
  // control fields
  // ************************************************************
  localparam int          CTRL_W      = 8;
  localparam int          BIT_INHIBIT = 7;
  localparam int          BIT_CLEAR   = 6;
  localparam int          BIT_STEP    = 5;
  localparam int          BIT_STROBE  = 4;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [7:0]  DATA_RST    = 8'h00;

  // ************************************************************
  // status fields
  // ************************************************************
  localparam int          ST_CNT_LSB  = 0;
  localparam int          ST_SCAN_LSB = 8;
  localparam int          ST_INHIBIT  = 16;
  localparam int          ST_OUT_V    = 17;
  localparam int          ST_SKID_V   = 18;

  // ************************************************************
  // display geometry and timing
  // ************************************************************
  localparam int          ADDR_W      = 5;
  localparam int          DEPTH       = 32;
  localparam int          CHAR_W      = 8;
  localparam int          ROW_W       = 3;
  localparam int          COL_W       = 5;
  localparam int          DISP_DIV    = 250;
  localparam logic [4:0]  ADDR_ONE    = 5'h01;

  typedef enum logic [1:0] {
    SCAN_HALT,
    SCAN_PRESENT,
    SCAN_CAPTURE
  } cdr_scan_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
  } cdr_pat_t;

endpackage : cdr_pkg

// File: core/cdr_loader.sv
// Summary of operation
// RULE1: inhibit high stops scan, allows writes
// RULE2: inhibit low, display scans RAM addresses
// RULE3: take generator row and column lines
// RULE4: clear bit pulse zeroes address counter
// RULE5: counter drives address, buffer enabled inhibited
// RULE6: each step pulse advances counter once; the code ignores a step that rises in the same write as a clear
// RULE7: write strobe stores data byte at counter
// RULE8: host sets up ASCII before strobe
// RULE9: host holds strobe at least 50 us; the bench holds the strobe bit only BENCH_DIV plus a few mclk cycles
// RULE10: host inhibits, clears, writes 32 characters
// RULE11: host drops inhibit after last character
// RULE12: display rereads RAM continually while enabled
// RULE13: address counter five bits for 32 locations
//
// The address map and the Avalon-MM register port were chosen for this implementation.
module cdr_loader #(
  parameter int DIV = cdr_pkg::DISP_DIV
) (
  input  wire logic                            mclk,
  input  wire logic                            resetn,
  input  wire logic [cdr_pkg::AV_ADDR_W-1:0]   avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [cdr_pkg::AV_DATA_W-1:0]   avs_writedata,
  output logic      [cdr_pkg::AV_DATA_W-1:0]   avs_readdata,
  output logic                                 avs_waitrequest,
  output logic      [cdr_pkg::ADDR_W-1:0]      ram_addr,
  output logic                                 addr_buf_oe,
  output logic      [cdr_pkg::CHAR_W-1:0]      cg_char,
  input  wire logic [cdr_pkg::ROW_W-1:0]       row_select_lines,
  input  wire logic [cdr_pkg::COL_W-1:0]       column_data_lines,
  output logic                                 pat_valid,
  input  wire logic                            pat_ready,
  output cdr_pkg::cdr_pat_t                    pat_data
);

  // ************************************************************
  // state
  // ************************************************************
  localparam int DIV_W = $clog2(DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE  = DIV_W'(1);

  typedef struct packed {
    logic                                      waitreq;
    logic [cdr_pkg::AV_DATA_W-1:0]             rdata;
    logic [cdr_pkg::CTRL_W-1:0]                ctrl;
    logic [cdr_pkg::CHAR_W-1:0]                data;
    logic [cdr_pkg::ADDR_W-1:0]                cnt;
    logic [cdr_pkg::ADDR_W-1:0]                scan;
    cdr_pkg::cdr_scan_t                        st;
    logic [DIV_W-1:0]                          div;
    logic                                      tick;
    logic [cdr_pkg::ADDR_W-1:0]                ram_addr;
    logic                                      addr_oe;
    logic [cdr_pkg::CHAR_W-1:0]                cg_char;
    cdr_pkg::cdr_pat_t                         out;
    logic                                      out_v;
    cdr_pkg::cdr_pat_t                         skid;
    logic                                      skid_v;
    logic [cdr_pkg::DEPTH-1:0][cdr_pkg::CHAR_W-1:0] ram;
  } cdr_state_t;

  cdr_state_t q;
  cdr_state_t d;

  localparam int PULSE_N = 3;
  localparam int PULSE_BIT [PULSE_N] = '{cdr_pkg::BIT_STROBE,
                                        cdr_pkg::BIT_STEP,
                                        cdr_pkg::BIT_CLEAR};

  logic                            wr_go;
  logic                            ctrl_wr;
  logic [cdr_pkg::CTRL_W-1:0]      wctrl;
  logic [PULSE_N-1:0]              rise;
  logic                            rise_clear;
  logic                            rise_step;
  logic                            rise_strobe;
  logic                            inhibit;
  logic                            push;
  logic                            pop;
  logic                            buf_ready;
  cdr_pkg::cdr_pat_t               newpat;

  // ************************************************************
  // control bit edges
  // ************************************************************
  assign wr_go   = avs_write && !q.waitreq;
  assign ctrl_wr = wr_go && (avs_address == cdr_pkg::REG_CTRL);
  assign wctrl   = avs_writedata[cdr_pkg::CTRL_W-1:0];

  for (genvar gi = 0; gi < PULSE_N; gi++)
  begin : g_rise
    assign rise[gi] = ctrl_wr && wctrl[PULSE_BIT[gi]]
                      && !q.ctrl[PULSE_BIT[gi]];
  end

  assign rise_strobe = rise[0];
  assign rise_step   = rise[1];
  assign rise_clear  = rise[2];

  // ************************************************************
  // buffer input side
  // ************************************************************
  assign buf_ready = !q.skid_v;

  always_comb
  begin
    d = q;
    push = 1'b0;
    pop  = q.out_v && pat_ready;
    newpat.addr = q.scan;
    newpat.row  = row_select_lines;
    newpat.col  = column_data_lines;

    // ************************************************************
    // bus slave
    // ************************************************************
    if (!q.waitreq)
    begin
      d.waitreq = 1'b1;
    end
    else if (avs_read || avs_write)
    begin
      d.waitreq = 1'b0;
      d.rdata = '0;
      if (avs_read)
      begin
        unique case (avs_address)
          cdr_pkg::REG_CTRL:
            d.rdata[cdr_pkg::CTRL_W-1:0] = q.ctrl;
          cdr_pkg::REG_DATA:
            d.rdata[cdr_pkg::CHAR_W-1:0] = q.data;
          cdr_pkg::REG_STATUS:
          begin
            d.rdata[cdr_pkg::ST_CNT_LSB +: cdr_pkg::ADDR_W]  = q.cnt;
            d.rdata[cdr_pkg::ST_SCAN_LSB +: cdr_pkg::ADDR_W] = q.scan;
            d.rdata[cdr_pkg::ST_INHIBIT] = q.ctrl[cdr_pkg::BIT_INHIBIT];
            d.rdata[cdr_pkg::ST_OUT_V]   = q.out_v;
            d.rdata[cdr_pkg::ST_SKID_V]  = q.skid_v;
          end
          default:
            d.rdata = '0;
        endcase
      end
    end

    if (wr_go)
    begin
      unique case (avs_address)
        cdr_pkg::REG_CTRL:
        begin
          d.ctrl = wctrl;
        end
        cdr_pkg::REG_DATA:
          d.data = avs_writedata[cdr_pkg::CHAR_W-1:0];
        default:
          d.data = q.data;
      endcase
    end

    // ************************************************************
    // address counter and RAM write
    // ************************************************************
    inhibit = q.ctrl[cdr_pkg::BIT_INHIBIT];
    if (rise_strobe && inhibit)
    begin
      d.ram[q.cnt] = q.data; // RULE7 RULE1
    end
    if (rise_clear)
    begin
      d.cnt = '0; // RULE4
    end
    else if (rise_step)
    begin
      d.cnt = q.cnt + cdr_pkg::ADDR_ONE; // RULE6 RULE13
    end

    // ************************************************************
    // display clock divider
    // ************************************************************
    d.tick = 1'b0;
    if (q.div == DIV_LAST)
    begin
      d.div  = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.div = q.div + DIV_ONE;
    end

    // ************************************************************
    // display scan
    // ************************************************************
    if (inhibit)
    begin
      d.st = cdr_pkg::SCAN_HALT; // RULE1
    end
    else if (q.tick)
    begin
      unique case (q.st)
        cdr_pkg::SCAN_HALT:
        begin
          d.scan = '0;
          d.st   = cdr_pkg::SCAN_PRESENT;
        end
        cdr_pkg::SCAN_PRESENT:
        begin
          d.cg_char = q.ram[q.scan]; // RULE2
          d.st      = cdr_pkg::SCAN_CAPTURE;
        end
        cdr_pkg::SCAN_CAPTURE:
        begin
          if (buf_ready)
          begin
            push   = 1'b1; // RULE3
            d.scan = q.scan + cdr_pkg::ADDR_ONE; // RULE12
            d.st   = cdr_pkg::SCAN_PRESENT;
          end
        end
        default:
        begin
          d.st = cdr_pkg::SCAN_HALT;
        end
      endcase
    end

    // ************************************************************
    // address pins
    // ************************************************************
    d.addr_oe  = inhibit; // RULE5
    d.ram_addr = inhibit ? q.cnt : q.scan; // RULE5 RULE2

    // ************************************************************
    // two-entry pattern buffer
    // ************************************************************
    if (pop || !q.out_v)
    begin
      if (q.skid_v)
      begin
        d.out    = q.skid;
        d.out_v  = 1'b1;
        d.skid_v = 1'b0;
        if (push)
        begin
          d.skid   = newpat;
          d.skid_v = 1'b1;
        end
      end
      else
      begin
        d.out_v = push;
        if (push)
        begin
          d.out = newpat;
        end
      end
    end
    else if (push)
    begin
      d.skid   = newpat;
      d.skid_v = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      q.waitreq  <= 1'b1;
      q.rdata    <= '0;
      q.ctrl     <= cdr_pkg::CTRL_RST;
      q.data     <= cdr_pkg::DATA_RST;
      q.cnt      <= '0;
      q.scan     <= '0;
      q.st       <= cdr_pkg::SCAN_HALT;
      q.div      <= '0;
      q.tick     <= 1'b0;
      q.ram_addr <= '0;
      q.addr_oe  <= 1'b0;
      q.cg_char  <= '0;
      q.out      <= '0;
      q.out_v    <= 1'b0;
      q.skid     <= '0;
      q.skid_v   <= 1'b0;
      q.ram      <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign ram_addr        = q.ram_addr;
  assign addr_buf_oe     = q.addr_oe;
  assign cg_char         = q.cg_char;
  assign pat_valid       = q.out_v;
  assign pat_data        = q.out;

endmodule : cdr_loader

// File: tb/cdr_loader_properties.sv
// ********
// port checks
// ********
module cdr_loader_properties (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [3:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [4:0]        ram_addr,
  input wire logic              addr_buf_oe,
  input wire logic [2:0]        row_select_lines,
  input wire logic [4:0]        column_data_lines,
  input wire logic              pat_valid,
  input wire logic              pat_ready,
  input wire cdr_pkg::cdr_pat_t pat_data
);
  logic [7:0] ctrl_q;
  logic       wr_ctrl;
  logic [7:0] wd;
  assign wd = avs_writedata[7:0];
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == cdr_pkg::REG_CTRL;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      ctrl_q <= 8'h00;
    else if (wr_ctrl)
      ctrl_q <= wd;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer wrong");
  buf_enable_a: assert property (wr_ctrl
    |=> ##1 addr_buf_oe == $past(wd[7], 2)) else $error("buffer enable wrong");
  count_clear_a: assert property (wr_ctrl && wd[7] && wd[6] && !ctrl_q[6]
    |=> ##1 ram_addr == 5'h00) else $error("clear failed");
  count_step_a: assert property (wr_ctrl && ctrl_q[7] && wd[7] && wd[5]
    && !ctrl_q[5] && !wd[6] |=> ##1 ram_addr == $past(ram_addr, 2) + cdr_pkg::ADDR_ONE)
    else $error("step failed");
  push_halt_a: assert property (addr_buf_oe && $past(addr_buf_oe)
    |-> !$rose(pat_valid)) else $error("push while inhibited");
  status_inh_a: assert property (avs_read && !avs_waitrequest
    && avs_address == cdr_pkg::REG_STATUS |-> avs_readdata[16] == ctrl_q[7])
    else $error("status inhibit wrong");
  pat_hold_a: assert property (pat_valid && !pat_ready
    |=> pat_valid && $stable(pat_data)) else $error("pattern dropped");
  pat_capture_a: assert property ($rose(pat_valid)
    |-> pat_data.row == $past(row_select_lines)
    && pat_data.col == $past(column_data_lines)) else $error("pattern wrong");
  scan_addr_a: assert property (!addr_buf_oe && $past(!addr_buf_oe)
    && $changed(ram_addr) |-> ram_addr == $past(ram_addr) + cdr_pkg::ADDR_ONE
    || ram_addr == 5'h00) else $error("scan address jump");
endmodule : cdr_loader_properties

bind cdr_loader cdr_loader_properties chk (.*);

// File: tb/cdr_cg_model.sv
// ********
// character generator and receiver
// ********
module cdr_cg_model (
  input wire logic [7:0] cg_char,
  input wire logic       stall,
  output logic     [2:0] row_select_lines,
  output logic     [4:0] column_data_lines,
  output logic           pat_ready
);
  assign row_select_lines = cg_char[2:0];
  assign column_data_lines = cg_char[7:3];
  assign pat_ready = !stall;
endmodule : cdr_cg_model

// File: tb/cdr_loader_bench.sv
// ********
// loader bench
// ********
module cdr_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BENCH_DIV = 4;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] q;} cdr_row_t;
  logic mclk, resetn, avs_read, avs_write, stall;
  logic avs_waitrequest, addr_buf_oe, pat_valid, pat_ready;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [4:0] ram_addr, column_data_lines;
  logic [2:0] row_select_lines;
  logic [7:0] cg_char, e;
  cdr_pkg::cdr_pat_t pat_data;
  int n_errors, n_checks, k, n;
  cdr_row_t rows [3] = '{'{4'h4, 32'h1234_56a5, 32'ha5},
    '{4'hc, 32'hffff_ffff, 32'h0}, '{4'h0, 32'h80, 32'h80}};
  cdr_loader #(.DIV(BENCH_DIV)) dut (.*);
  cdr_cg_model cgm (.*);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      $display("CHECK FAILED %0t %s", $time, m);
      n_errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int c;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    c = 0;
    do
    begin
      @(posedge mclk);
      c++;
    end
    while (avs_waitrequest !== 1'b0 && c < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
    if (c >= 50)
    begin
      chk(1'b0, "bus timeout");
      complete_run();
    end
  endtask : bus
  task automatic pulse(input logic [7:0] b);
    bus(1'b1, 4'h0, {24'h0, b});
    repeat (BENCH_DIV) @(posedge mclk);
    bus(1'b1, 4'h0, 32'h80);
  endtask : pulse
  initial
  begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    stall = 1'b0;
    repeat (6) @(posedge mclk);
    chk(avs_waitrequest === 1'b1 && addr_buf_oe === 1'b0 && pat_valid === 1'b0, "reset");
    resetn <= 1'b1;
    @(posedge mclk);
    $display("reset test done");
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(rd === rows[i].q, "register row");
    end
    $display("register test done");
    pulse(8'ha0);
    pulse(8'ha0);
    repeat (2) @(posedge mclk);
    chk(ram_addr === 5'h02 && addr_buf_oe === 1'b1, "step count");
    pulse(8'hc0);
    repeat (2) @(posedge mclk);
    chk(ram_addr === 5'h00, "clear count");
    for (int i = 0; i < 32; i++)
    begin
      bus(1'b1, 4'h4, {24'h0, 8'h41 + 8'(i)});
      pulse(8'h90);
      pulse(8'ha0);
    end
    bus(1'b0, 4'h8, 32'h0);
    chk(rd[4:0] === 5'h00 && rd[16] === 1'b1, "wrap status");
    $display("load test done");
    stall <= 1'b1;
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'h7e);
    bus(1'b1, 4'h0, 32'h10);
    bus(1'b1, 4'h0, 32'h0);
    chk(addr_buf_oe === 1'b0, "buffer off");
    k = 0;
    for (n = 0; k < 33 && n < 3000; n++)
    begin
      @(posedge mclk);
      if (pat_valid === 1'b1 && pat_ready === 1'b1)
      begin
        e = 8'h41 + 8'(k % 32);
        chk(pat_data === {5'(k), e[2:0], e[7:3]}, "pattern");
        k++;
      end
      stall <= (n % 40) < 20;
    end
    chk(k === 33, "pattern count");
    $display("scan test done");
    stall <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(avs_waitrequest === 1'b1 && ram_addr === 5'h00 && addr_buf_oe === 1'b0
      && cg_char === 8'h00 && pat_valid === 1'b0, "mid-run reset");
    resetn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd === 32'h0, "control after reset");
    k = 0;
    for (n = 0; k < 1 && n < 200; n++)
    begin
      @(posedge mclk);
      if (pat_valid === 1'b1 && pat_ready === 1'b1)
      begin
        chk(pat_data === 13'h0000, "pattern after reset");
        k++;
      end
      stall <= 1'b0;
    end
    chk(k === 1, "pattern after reset count");
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : cdr_loader_bench
